// ### fmac_pkg.sv
// Package for the fault mask and converter monitor control registers.
// Assumes an 8-bit register port with byte addresses from a serial front end.
package fmac_pkg;

  // Register offsets
  localparam logic [7:0] OFS_MASK_A = 8'h2C;
  localparam logic [7:0] OFS_MASK_B = 8'h2D;
  localparam logic [7:0] OFS_MON_CTRL = 8'h2E;

  // Reset values
  localparam logic [7:0] RST_MASK_A = 8'h00;
  localparam logic [7:0] RST_MASK_B = 8'h00;
  localparam logic [7:0] RST_MON_CTRL = 8'h30;

  // Writable bits of the second mask; bits 1-0 are read-only zero
  localparam logic [7:0] WMASK_MASK_B = 8'hFC;

  // Field positions in the first mask register
  localparam int BIT_BATT_CUR_REG = 7;
  localparam int BIT_BUS_OV = 6;
  localparam int BIT_BATT_OV = 5;
  localparam int BIT_BUS_OC = 4;
  localparam int BIT_BATT_OC = 3;
  localparam int BIT_CONV_OC = 2;
  localparam int BIT_IN2_OV = 1;
  localparam int BIT_IN1_OV = 0;

  // Field positions in the second mask register
  localparam int BIT_RAIL_SHORT = 7;
  localparam int BIT_RAIL_OV = 6;
  localparam int BIT_SRC_OV = 5;
  localparam int BIT_SRC_UV = 4;
  localparam int BIT_SPARE_B3 = 3;
  localparam int BIT_THERM_SD = 2;

  // Field positions in the monitor control register
  localparam int BIT_MON_EN = 7;
  localparam int BIT_MON_ONESHOT = 6;
  localparam int BIT_SPEED_HI = 5;
  localparam int BIT_SPEED_LO = 4;
  localparam int BIT_AVG = 3;
  localparam int BIT_AVG_SEED = 2;

  // Fault event count: 8 in the first register, 6 in the second
  localparam int N_EVENTS = 14;

  // Resolution code of the sample speed field
  typedef enum logic [1:0] {
    RES15 = 2'h0,
    RES14 = 2'h1,
    RES13 = 2'h2,
    RES12 = 2'h3
  } fmac_res_type;

  // Register write request from the serial port
  typedef struct packed {
    logic       wrEn;
    logic [7:0] addr;
    logic [7:0] data;
  } fmac_wr_type;

  // Decoded monitor configuration
  typedef struct packed {
    logic         enable;
    logic         oneShot;
    fmac_res_type resolution;
    logic         averaging;
    logic         seedFresh;
  } fmac_mon_type;

  // True when the address is one of the two fault mask registers
  function automatic logic isMaskedAddr(input logic [7:0] a);
    isMaskedAddr = (a == OFS_MASK_A) || (a == OFS_MASK_B);
  endfunction

endpackage : fmac_pkg

// ### fmac_irq_gate.sv
// Gates fault events with the mask bits and forms one interrupt pulse.
// Assumes events are one-cycle pulses synchronous to core_clk.
`timescale 1ns/1ns
module fmac_irq_gate #(
  parameter int N = 14
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic [N-1:0] events,
  input  wire logic [N-1:0] block,
  output logic              irqPulse
);
  import fmac_pkg::*;

  // Refuse a width that does not match the event map
  if (N != N_EVENTS) begin : g_chk
    $error("fmac_irq_gate: N must equal N_EVENTS");
  end

  // Any unblocked event pulses the output one cycle later
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irqPulse <= 1'b0;
    end else begin
      irqPulse <= |(events & ~block);
    end
  end

  // An unblocked event must pulse the output next cycle
  a_gate_pass: assert property ( // RQ1 RQ8 RQ11
    @(posedge core_clk) disable iff (rst)
    |(events & ~block) |=> irqPulse)
    else $error("unblocked event gave no pulse");
  // Fully blocked events must stay silent
  a_gate_block: assert property ( // RQ2 RQ9 RQ10
    @(posedge core_clk) disable iff (rst)
    !(|(events & ~block)) |=> !irqPulse)
    else $error("blocked event pulsed interrupt");

endmodule // fmac_irq_gate

// ### fmac_monitor_cfg.sv
// Decodes the monitor control byte into a configuration struct.
// Assumes the byte comes straight from the control register.
`timescale 1ns/1ns
module fmac_monitor_cfg (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic [7:0]       ctrlByte,
  output fmac_pkg::fmac_mon_type cfg
);
  import fmac_pkg::*;

  // Registered decode keeps the output a flop
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cfg <= '{1'b0, 1'b0, RES12, 1'b0, 1'b0};
    end else begin
      cfg.enable     <= ctrlByte[BIT_MON_EN]; // RQ19
      cfg.oneShot    <= ctrlByte[BIT_MON_ONESHOT]; // RQ15
      // RQ16
      cfg.resolution <= fmac_res_type'(ctrlByte[BIT_SPEED_HI:BIT_SPEED_LO]);
      cfg.averaging  <= ctrlByte[BIT_AVG]; // RQ17
      cfg.seedFresh  <= ctrlByte[BIT_AVG_SEED]; // RQ18
    end
  end

endmodule // fmac_monitor_cfg

// ### fmac_regs.sv
// Fault mask and converter monitor control register bank.
// Assumes a serial front end delivering byte writes and read addresses,
// fault detectors giving one-cycle event pulses, and a watchdog pulse.
//
// Behaviour
// RQ1 - Mask A bit7 blocks battery current regulation IRQ
// RQ2 - Mask A bit6 blocks bus overvoltage IRQ
// RQ3 - Mask A bit5 blocks battery overvoltage IRQ
// RQ4 - Mask A bit4 blocks bus overcurrent IRQ
// RQ5 - Mask A bit3 blocks battery overcurrent IRQ
// RQ6 - Mask A bit2 blocks converter overcurrent IRQ
// RQ7 - Mask A bits1,0 block input2, input1 overvoltage
// RQ8 - Mask B bit7 blocks rail short IRQ
// RQ9 - Mask B bit6 blocks rail overvoltage IRQ
// RQ10 - Mask B bits5,4 block source-mode over/undervoltage
// RQ11 - Mask B bit2 blocks thermal shutdown IRQ
// RQ12 - Mask A at 2Ch, resets to zero
// RQ13 - Mask B at 2Dh, zero; bits1-0 read zero
// RQ14 - Monitor control at 2Eh, resets to 30h
// RQ15 - Bit6: continuous when 0, one-shot when 1
// RQ16 - Bits5-4 select resolution 15 down to 12
// RQ17 - Bit3: single value or running average
// RQ18 - Bit2: seed average from register or fresh
// RQ19 - Bit7 enables monitor; watchdog also clears it
// RQ20 - Register reset restores all fields; reserved read zero; control bits 1-0 here store and read back written data
`timescale 1ns/1ns
module fmac_regs (
  input  wire logic                     core_clk,
  input  wire logic                     rst,
  input  wire logic                     regReset,
  input  wire logic                     watchdogExpired,
  input  wire fmac_pkg::fmac_wr_type    wrReq,
  input  wire logic [7:0]               rdAddr,
  input  wire logic [7:0]               battCurrentRegEvent,
  input  wire logic [5:0]               railEvent,
  output logic [7:0]                    rdData,
  output logic                          irqPulse,
  output fmac_pkg::fmac_mon_type        monitorCfg
);
  import fmac_pkg::*;

  // Register state
  logic [7:0] maskA_q;       // First fault mask
  logic [7:0] maskB_q;       // Second fault mask
  logic [7:0] monCtrl_q;     // Monitor control
  logic [7:0] rdData_d;      // Read mux output
  logic [N_EVENTS-1:0] events;  // Event vector, A in top byte
  logic [N_EVENTS-1:0] blocks;  // Matching block bits

  // Write strobes per register
  logic wrA;
  logic wrB;
  logic wrC;

  // Address decode of writes
  always_comb begin
    wrA = 1'b0;
    wrB = 1'b0;
    wrC = 1'b0;
    if (wrReq.wrEn && wrReq.addr == OFS_MASK_A) begin
      wrA = 1'b1; // RQ12
    end else if (wrReq.wrEn && wrReq.addr == OFS_MASK_B) begin
      wrB = 1'b1; // RQ13
    end else if (wrReq.wrEn && wrReq.addr == OFS_MON_CTRL) begin
      wrC = 1'b1; // RQ14
    end
  end

  // First fault mask; software reset wins over a write
  always_ff @(posedge core_clk) begin
    if (rst || regReset) begin
      maskA_q <= RST_MASK_A; // RQ12 RQ20
    end else if (wrA) begin
      maskA_q <= wrReq.data;
    end
  end

  // Second fault mask; low two bits never store a one
  always_ff @(posedge core_clk) begin
    if (rst || regReset) begin
      maskB_q <= RST_MASK_B; // RQ13 RQ20
    end else if (wrB) begin
      maskB_q <= wrReq.data & WMASK_MASK_B; // RQ13
    end
  end

  // Monitor control; the watchdog only drops the enable bit
  always_ff @(posedge core_clk) begin
    if (rst || regReset) begin
      monCtrl_q <= RST_MON_CTRL; // RQ14 RQ20
    end else begin
      if (wrC) begin
        monCtrl_q <= wrReq.data;
      end
      // Watchdog overrides a same-cycle write of the enable
      if (watchdogExpired) begin
        monCtrl_q[BIT_MON_EN] <= 1'b0; // RQ19
      end
    end
  end

  // Read mux; bits 1-0 of the control byte are writable scratch
  always_comb begin
    rdData_d = 8'h00;
    if (rdAddr == OFS_MASK_A) begin
      rdData_d = maskA_q;
    end else if (rdAddr == OFS_MASK_B) begin
      rdData_d = maskB_q & WMASK_MASK_B; // RQ13 RQ20
    end else if (rdAddr == OFS_MON_CTRL) begin
      rdData_d = monCtrl_q;
    end
  end

  // Registered read data
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdData <= 8'h00;
    end else begin
      rdData <= rdData_d;
    end
  end

  // Event map: first-mask events in positions 13..6 of the vector
  // Events index 7..0 of battCurrentRegEvent follow mask A bit order
  always_comb begin
    events = {battCurrentRegEvent, railEvent};
    // RQ1 RQ2 RQ3 RQ4 RQ5 RQ6 RQ7
    blocks[13:6] = maskA_q;
    // Rail short, rail OV, source OV, source UV, spare, thermal
    // RQ8 RQ9 RQ10 RQ11
    blocks[5:0] = {maskB_q[BIT_RAIL_SHORT], maskB_q[BIT_RAIL_OV],
                   maskB_q[BIT_SRC_OV], maskB_q[BIT_SRC_UV],
                   maskB_q[BIT_SPARE_B3], maskB_q[BIT_THERM_SD]};
  end

  // Mask gate and pulse former
  fmac_irq_gate #(
    .N (N_EVENTS)
  ) u_gate (
    .core_clk (core_clk),
    .rst      (rst),
    .events   (events),
    .block    (blocks),
    .irqPulse (irqPulse)
  );

  // Monitor configuration decode
  // RQ15 RQ16 RQ17 RQ18 RQ19
  fmac_monitor_cfg u_cfg (
    .core_clk (core_clk),
    .rst      (rst),
    .ctrlByte (monCtrl_q),
    .cfg      (monitorCfg)
  );

  // Assertions
  a_reset_masks: assert property ( // RQ12 RQ20
    @(posedge core_clk) disable iff (rst)
    regReset |=> (maskA_q == RST_MASK_A && maskB_q == RST_MASK_B))
    else $error("masks not cleared by register reset");
  a_reset_ctrl: assert property ( // RQ14
    @(posedge core_clk) disable iff (rst)
    regReset |=> monCtrl_q == RST_MON_CTRL)
    else $error("control not 30h after register reset");
  a_resb_zero: assert property ( // RQ13
    @(posedge core_clk) disable iff (rst)
    rdAddr == OFS_MASK_B |=> rdData[1:0] == 2'h0)
    else $error("mask B reserved bits read nonzero");
  a_wdog_clear: assert property ( // RQ19
    @(posedge core_clk) disable iff (rst)
    watchdogExpired && !regReset |=> !monCtrl_q[7] ##1 !monitorCfg.enable)
    else $error("watchdog did not clear enable");
  a_batt_cur_block: assert property ( // RQ1
    @(posedge core_clk) disable iff (rst)
    battCurrentRegEvent == 8'h80 && railEvent == 6'h00 && maskA_q[7]
    |=> !irqPulse)
    else $error("blocked current regulation pulsed");
  a_therm_pass: assert property ( // RQ11
    @(posedge core_clk) disable iff (rst)
    railEvent[0] && !maskB_q[2] |=> irqPulse)
    else $error("thermal event gave no pulse");
  a_rail_short: assert property ( // RQ8
    @(posedge core_clk) disable iff (rst)
    railEvent == 6'h20 && battCurrentRegEvent == 8'h00 && maskB_q[7]
    |=> !irqPulse)
    else $error("blocked rail short pulsed");
  a_cfg_follow: assert property ( // RQ16
    @(posedge core_clk) disable iff (rst)
    wrC && !regReset && !watchdogExpired
    |=> ##1 (monitorCfg.oneShot == $past(wrReq.data[6], 2) &&
    monitorCfg.resolution == $past(wrReq.data[5:4], 2) &&
    monitorCfg.averaging == $past(wrReq.data[3], 2) &&
    monitorCfg.seedFresh == $past(wrReq.data[2], 2)))
    else $error("monitor config not following write");

  c_mask_write: cover property (@(posedge core_clk) wrA ##1 !rst);
  c_irq: cover property (@(posedge core_clk) irqPulse);
  c_wdog: cover property (@(posedge core_clk)
    monCtrl_q[7] ##1 watchdogExpired);

endmodule // fmac_regs

// ### fmac_host_model.sv
// Host model: issues register writes and reads, counts interrupt pulses.
// Assumes rdData answers on the same edge that samples rdAddr.
`timescale 1ns/1ns
module fmac_host_model (
  input  wire logic           core_clk,
  output fmac_pkg::fmac_wr_type wrReq,
  output logic [7:0]          rdAddr,
  input  wire logic [7:0]     rdData,
  input  wire logic           irqPulse,
  output int unsigned         irqCnt
);
  import fmac_pkg::*;

  // Idle bus at time zero
  initial begin
    wrReq  = '0;
    rdAddr = 8'h00;
    irqCnt = 0;
  end

  // Pulse counter; unknown level never counts
  always @(posedge core_clk) begin
    if (irqPulse === 1'b1) begin
      irqCnt <= irqCnt + 1;
    end
  end

  // One-cycle write strobe, then an idle edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    wrReq <= '{wrEn: 1'b1, addr: a, data: d};
    @(posedge core_clk);
    wrReq.wrEn <= 1'b0;
  endtask

  // Address held over the sampling edge, data taken once settled
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    rdAddr <= a;
    @(posedge core_clk);
    #1 d = rdData;
  endtask
endmodule // fmac_host_model

// ### testbench.sv
// Self-checking bench for the fault mask and monitor control bank.
// Assumes the host model drives the register port for the bench.
`timescale 1ns/1ns
module testbench;
  import fmac_pkg::*;

  logic               core_clk = 1'b0;
  logic               rst = 1'b1;
  logic               regReset = 1'b0;
  logic               watchdogExpired = 1'b0;
  logic [7:0]         evA = 8'h00;
  logic [5:0]         evB = 6'h00;
  fmac_wr_type        wrReq;
  logic [7:0]         rdAddr;
  logic [7:0]         rdData;
  logic               irqPulse;
  fmac_mon_type       monitorCfg;
  int unsigned        irqCnt;
  int                 error_cnt = 0;
  int                 n_checks = 0;
  logic [31:0]        seed = 32'h97D7;

  // 250 MHz clock
  always #2 core_clk = ~core_clk;

  fmac_regs fmac_regs_inst (
    .core_clk(core_clk), .rst(rst), .regReset(regReset),
    .watchdogExpired(watchdogExpired), .wrReq(wrReq), .rdAddr(rdAddr),
    .battCurrentRegEvent(evA), .railEvent(evB), .rdData(rdData),
    .irqPulse(irqPulse), .monitorCfg(monitorCfg)
  );

  fmac_host_model host (
    .core_clk(core_clk), .wrReq(wrReq), .rdAddr(rdAddr),
    .rdData(rdData), .irqPulse(irqPulse), .irqCnt(irqCnt)
  );

  // Repeatable pseudo-random source
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    chk("rdData", e, d);
  endtask

  // Expected pulses of one burst: one if any event is not blocked
  function automatic logic [7:0] expIrq(input logic [13:0] ev,
                                        input logic [13:0] m);
    return 8'(|(ev & ~m));
  endfunction

  // Writes both masks from a 14-bit view, pulses events for one cycle
  task automatic fire(input logic [13:0] ev, input logic [13:0] m);
    int unsigned c0;
    host.wr(OFS_MASK_A, m[7:0]);
    host.wr(OFS_MASK_B, {m[13:8], 2'b11});
    c0 = irqCnt;
    @(posedge core_clk);
    evA <= ev[7:0];
    evB <= ev[13:8];
    @(posedge core_clk);
    evA <= 8'h00;
    evB <= 6'h00;
    repeat (3) @(posedge core_clk);
    #1;
    chk("irqCount", expIrq(ev, m), 8'(irqCnt - c0));
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Hang guard
  initial begin
    #400000;
    error_cnt++;
    give_verdict();
  end

  initial begin
    logic [7:0] c;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    rdChk(OFS_MASK_A, 8'h00);
    rdChk(OFS_MASK_B, 8'h00);
    rdChk(OFS_MON_CTRL, 8'h30);
    rdChk(8'h2F, 8'h00);
    chk("cfg", 8'h0C, {2'h0, monitorCfg});
    // Each event alone: unmasked fires, all others masked stay silent
    for (int k = 0; k < 14; k++) begin
      fire(14'h0001 << k, ~(14'h0001 << k));
      fire(~(14'h0001 << k), ~(14'h0001 << k));
      fire(14'h0001 << k, 14'h0001 << k);
    end
    // Random mixes, with readback of the stored masks
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(lfsr(lfsr(seed)));
      fire(seed[13:0], seed[29:16]);
      rdChk(OFS_MASK_A, seed[23:16]);
      rdChk(OFS_MASK_B, {seed[29:24], 2'b00});
    end
    // Every resolution code with random companion bits
    for (int r = 0; r < 4; r++) begin
      seed = lfsr(lfsr(seed));
      c = {seed[7:6], 2'(r), seed[3:0]};
      host.wr(OFS_MON_CTRL, c);
      rdChk(OFS_MON_CTRL, c);
      chk("cfg", {2'h0, c[7:2]}, {2'h0, monitorCfg});
    end
    // Watchdog lands on the same edge as a write setting enable
    host.wr(OFS_MON_CTRL, 8'hC5);
    fork
      host.wr(OFS_MON_CTRL, 8'hFF);
      begin
        @(posedge core_clk);
        watchdogExpired <= 1'b1;
        @(posedge core_clk);
        watchdogExpired <= 1'b0;
      end
    join
    rdChk(OFS_MON_CTRL, 8'h7F);
    chk("cfg", 8'h1F, {2'h0, monitorCfg});
    // Software reset after both masks were written to all ones
    host.wr(OFS_MASK_A, 8'hFF);
    host.wr(OFS_MASK_B, 8'hFF);
    // Register reset lands on the same edge as a mask write
    fork
      host.wr(OFS_MASK_A, 8'h5A);
      begin
        @(posedge core_clk);
        regReset <= 1'b1;
        @(posedge core_clk);
        regReset <= 1'b0;
      end
    join
    rdChk(OFS_MASK_A, 8'h00);
    rdChk(OFS_MASK_B, 8'h00);
    rdChk(OFS_MON_CTRL, 8'h30);
    chk("cfg", 8'h0C, {2'h0, monitorCfg});
    give_verdict();
  end
endmodule // testbench
